// ===== rtl/strobed_parallel_port.sv
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module strobed_parallel_port
  import spp_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic      [31:0] PRDATA,
  output logic             PSLVERR,
  // Port 0 data lines
  input  wire logic [7:0]  P0_IN,
  output logic      [7:0]  P0_OUT,
  output logic             P0_OE,
  // Port 1 strobe lines
  input  wire logic [7:0]  P1_IN,
  output logic      [7:0]  P1_OUT,
  output logic      [7:0]  P1_OE,
  // Acknowledge from the external device
  input  wire logic        ACK_IN
);

  typedef struct packed {
    state_t      st;
    logic [6:0]  tmr;
    logic [17:0] ns;
    logic [2:0]  idx;
    logic [7:0]  p0_out;
    logic        p0_oe;
    logic [7:0]  p1_out;
    logic [7:0]  p1_oe;
    logic [2:0]  sel;
    logic        pol;
    logic        ack_en;
    logic [2:0]  cnt;
    logic [7:0]  byte_gap_count;
    logic        buf_en;
    logic        ser_on;
    logic [63:0] wdata;
    logic [7:0]  rd_byte;
    logic        ovf;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        strb_d;
    logic [7:0]  p0_s1;
    logic [7:0]  p0_s2;
    logic [7:0]  p1_s1;
    logic [7:0]  p1_s2;
    logic        ack_s1;
    logic        ack_s2;
  } port_t;

  port_t       r_ff;
  port_t       nxt_r;
  logic        push;
  logic        pop;
  logic [7:0]  fifo_dout;
  logic [2:0]  fifo_level;
  logic        fifo_full;
  logic        fifo_empty;
  logic [17:0] gap_target;
  logic        wr_acc;
  logic        rd_acc;
  logic        strb_now;
  logic        strb_edge;
  logic        tmr_done;

  function automatic logic [7:0] pin_mask(input logic [2:0] s);
    return 8'h01 << s;
  endfunction

  function automatic logic [7:0] strobe_lvl(input logic [2:0] s,
                                            input logic       p,
                                            input logic       act);
    logic [7:0] m;
    m = pin_mask(s);
    // Selected pin sits at p when active and at !p when not
    return (act == p) ? m : ~m;
  endfunction

  assign gap_target = GAP_BASE_W
                      + 18'(GAP_STEP_W * {10'h000, r_ff.byte_gap_count});
  assign wr_acc    = PSEL && PENABLE && r_ff.pready && PWRITE;
  assign rd_acc    = PSEL && PENABLE && r_ff.pready && !PWRITE;
  assign strb_now  = r_ff.p1_s2[r_ff.sel];
  assign strb_edge = r_ff.pol ? (strb_now && !r_ff.strb_d)
                              : (!strb_now && r_ff.strb_d);
  assign tmr_done  = (r_ff.tmr >= STROBE_LAST);

  // Captures only while idle, so the port does not read its own strobe while a sequence runs
  assign push = strb_edge && r_ff.buf_en && !r_ff.ser_on
                && (r_ff.st == S_IDLE);
  assign pop  = rd_acc && (PADDR == OFS_RBUF);

  read_fifo u_fifo (
    .CLK   (CLK),
    .RST   (RST),
    .push  (push),
    .din   (r_ff.p0_s2),
    .pop   (pop),
    .dout  (fifo_dout),
    .level (fifo_level),
    .full  (fifo_full),
    .empty (fifo_empty)
  );

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    nxt_r = r_ff;
    nxt_r.p0_s1  = P0_IN;
    nxt_r.p0_s2  = r_ff.p0_s1;
    nxt_r.p1_s1  = P1_IN;
    nxt_r.p1_s2  = r_ff.p1_s1;
    nxt_r.ack_s1 = ACK_IN;
    nxt_r.ack_s2 = r_ff.ack_s1;
    nxt_r.strb_d = strb_now;
    nxt_r.pready = 1'b0;

    // Three-cycle access (one wait state): the answer is prepared one cycle ahead
    if (PSEL && PENABLE && !r_ff.pready) begin
      nxt_r.pready  = 1'b1;
      nxt_r.pslverr = 1'b0;
      nxt_r.prdata  = 32'h0000_0000;
      unique case (PADDR)
        OFS_CTRL: begin
          nxt_r.prdata[CTRL_SEL +: 3] = r_ff.sel;
          nxt_r.prdata[CTRL_POL]      = r_ff.pol;
          nxt_r.prdata[CTRL_ACK]      = r_ff.ack_en;
          nxt_r.prdata[CTRL_CNT +: 3] = r_ff.cnt;
          nxt_r.prdata[CTRL_BUFEN]    = r_ff.buf_en;
          nxt_r.prdata[CTRL_SER]      = r_ff.ser_on;
          nxt_r.prdata[CTRL_GAP +: 8] = r_ff.byte_gap_count;
        end
        OFS_WLO: nxt_r.prdata = r_ff.wdata[31:0];
        OFS_WHI: nxt_r.prdata = r_ff.wdata[63:32];
        OFS_STAT: begin
          nxt_r.prdata[STAT_BUSY]       = (r_ff.st != S_IDLE);
          nxt_r.prdata[STAT_OVF]        = r_ff.ovf;
          nxt_r.prdata[STAT_LEVEL +: 3] = fifo_level;
          nxt_r.prdata[STAT_RBYTE +: 8] = r_ff.rd_byte;
        end
        OFS_RBUF: begin
          nxt_r.prdata[7:0]        = fifo_dout;
          nxt_r.prdata[RBUF_VALID] = !fifo_empty;
        end
        default: nxt_r.pslverr = 1'b1;
      endcase
    end

    // Writes while busy, except the overflow clear, are dropped so a running sequence stays whole
    if (wr_acc && r_ff.st == S_IDLE) begin
      unique case (PADDR)
        OFS_CTRL: begin
          nxt_r.sel            = PWDATA[CTRL_SEL +: 3];
          nxt_r.pol            = PWDATA[CTRL_POL];
          nxt_r.ack_en         = PWDATA[CTRL_ACK];
          nxt_r.cnt            = PWDATA[CTRL_CNT +: 3];
          nxt_r.buf_en         = PWDATA[CTRL_BUFEN];
          nxt_r.ser_on         = PWDATA[CTRL_SER];
          nxt_r.byte_gap_count = PWDATA[CTRL_GAP +: 8];
        end
        OFS_WLO: nxt_r.wdata[31:0]  = PWDATA;
        OFS_WHI: nxt_r.wdata[63:32] = PWDATA;
        default: ;
      endcase
    end
    if (wr_acc && PADDR == OFS_STAT && PWDATA[STAT_OVF]) begin
      nxt_r.ovf = 1'b0;
    end

    // ********************************************************
    // Strobe sequencer
    // ********************************************************
    // Saturates, so a long ack stretch cannot wrap the width count
    nxt_r.tmr = tmr_done ? r_ff.tmr : r_ff.tmr + 7'h01;
    unique case (r_ff.st)
      S_IDLE: begin
        nxt_r.p0_oe  = 1'b0;
        nxt_r.p1_oe  = 8'h00;
        nxt_r.p1_out = IDLE_BYTE;
        nxt_r.tmr    = 7'h00;
        if (wr_acc && PADDR == OFS_CTRL && PWDATA[CTRL_WSTART]) begin
          nxt_r.st     = S_WSTB;
          nxt_r.idx    = 3'h0;
          nxt_r.p0_out = r_ff.wdata[7:0];
          nxt_r.p0_oe  = 1'b1;
          nxt_r.p1_oe  = pin_mask(PWDATA[CTRL_SEL +: 3]);
          nxt_r.p1_out = strobe_lvl(PWDATA[CTRL_SEL +: 3],
                                    PWDATA[CTRL_POL], 1'b1);
        end else if (wr_acc && PADDR == OFS_CTRL
                     && PWDATA[CTRL_RSTART]) begin
          nxt_r.st     = S_RSTB;
          nxt_r.p1_oe  = pin_mask(PWDATA[CTRL_SEL +: 3]);
          nxt_r.p1_out = strobe_lvl(PWDATA[CTRL_SEL +: 3],
                                    PWDATA[CTRL_POL], 1'b1);
        end
      end
      S_WSTB: begin
        // Ack low stretches the strobe past its minimum width
        if (tmr_done && (!r_ff.ack_en || r_ff.ack_s2)) begin
          nxt_r.st     = S_WEND;
          nxt_r.p1_out = strobe_lvl(r_ff.sel, r_ff.pol, 1'b0);
        end
      end
      S_WEND: begin
        nxt_r.p0_out = IDLE_BYTE;
        nxt_r.ns     = 18'h00000;
        if (r_ff.idx == r_ff.cnt) begin
          nxt_r.st = S_IDLE;
        end else begin
          nxt_r.st = S_GAP;
        end
      end
      S_GAP: begin
        nxt_r.ns = r_ff.ns + CLK_PERIOD_W;
        if (r_ff.ns + CLK_PERIOD_W >= gap_target) begin
          nxt_r.st     = S_WSTB;
          nxt_r.tmr    = 7'h00;
          nxt_r.idx    = r_ff.idx + 3'h1;
          nxt_r.p0_out = r_ff.wdata[{r_ff.idx + 3'h1, 3'b000} +: 8];
          nxt_r.p1_out = strobe_lvl(r_ff.sel, r_ff.pol, 1'b1);
        end
      end
      S_RSTB: begin
        if (tmr_done) begin
          nxt_r.rd_byte = r_ff.p0_s2;
          nxt_r.p1_out  = strobe_lvl(r_ff.sel, r_ff.pol, 1'b0);
          nxt_r.st      = S_IDLE;
        end
      end
      default: begin
        nxt_r.st = S_IDLE;
      end
    endcase

    // Overflow set wins over a clear in the same cycle
    if (push && fifo_full) begin
      nxt_r.ovf = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r_ff        <= '0;
      r_ff.st     <= S_IDLE;
      r_ff.p0_out <= IDLE_BYTE;
      r_ff.p1_out <= IDLE_BYTE;
      r_ff.pol    <= 1'b1;
      // Start at the pull-up level so no false edge follows reset
      r_ff.p1_s1  <= IDLE_BYTE;
      r_ff.p1_s2  <= IDLE_BYTE;
      r_ff.strb_d <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign PREADY  = r_ff.pready;
  assign PRDATA  = r_ff.prdata;
  assign PSLVERR = r_ff.pslverr;
  assign P0_OUT  = r_ff.p0_out;
  assign P0_OE   = r_ff.p0_oe;
  assign P1_OUT  = r_ff.p1_out;
  assign P1_OE   = r_ff.p1_oe;

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence read_done_s;
    r_ff.st == S_RSTB && tmr_done;
  endsequence

  sequence byte_released_s;
    r_ff.st == S_WEND ##1 r_ff.p0_out == IDLE_BYTE;
  endsequence

  strobe_width_a: assert property (
    r_ff.st == S_WSTB && !tmr_done |=> r_ff.st == S_WSTB)
    else $error("write strobe ended before its minimum width");
  restore_ff_a: assert property (
    r_ff.st == S_WSTB ##1 r_ff.st == S_WEND |-> byte_released_s)
    else $error("port 0 not restored after a byte");
  ack_hold_a: assert property (
    r_ff.st == S_WSTB && r_ff.ack_en && !r_ff.ack_s2 |=>
    r_ff.st == S_WSTB)
    else $error("strobe dropped while ack held low");
  wr_polarity_a: assert property (
    r_ff.st == S_WSTB |-> r_ff.p1_out[r_ff.sel] == r_ff.pol
    && r_ff.p1_oe == pin_mask(r_ff.sel))
    else $error("write strobe level or pin wrong");
  data_drive_a: assert property (
    r_ff.st == S_WSTB |-> r_ff.p0_oe
    && r_ff.p0_out == r_ff.wdata[{r_ff.idx, 3'b000} +: 8])
    else $error("port 0 not driving the current byte");
  lsb_first_a: assert property (
    r_ff.st == S_IDLE ##1 r_ff.st == S_WSTB |-> r_ff.idx == 3'h0)
    else $error("write did not start at byte zero");
  gap_len_a: assert property (
    r_ff.st == S_GAP && r_ff.ns + CLK_PERIOD_W < gap_target |=>
    r_ff.st == S_GAP)
    else $error("byte gap left early");
  read_latch_a: assert property (
    read_done_s |=> r_ff.rd_byte == $past(r_ff.p0_s2)
    && r_ff.p1_out[r_ff.sel] != r_ff.pol)
    else $error("read latch or strobe release wrong");
  rd_polarity_a: assert property (
    r_ff.st == S_RSTB |-> r_ff.p1_out[r_ff.sel] == r_ff.pol)
    else $error("read strobe level wrong");
  overflow_set_a: assert property (
    push && fifo_full |=> r_ff.ovf && fifo_level == $past(fifo_level))
    else $error("overflow not flagged or byte kept");
  serial_block_a: assert property (
    r_ff.ser_on |=> fifo_level <= $past(fifo_level))
    else $error("buffer captured while serial active");

endmodule
`default_nettype wire

// ===== common/spp_pkg.sv
package spp_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS     = 1500;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam logic [6:0]  STROBE_LAST  = 7'(STROBE_CYC - 1);
  localparam int GAP_BASE_NS   = 8250;
  localparam int GAP_STEP_NS   = 750;
  localparam logic [17:0] GAP_BASE_W   = 18'(GAP_BASE_NS);
  localparam logic [17:0] GAP_STEP_W   = 18'(GAP_STEP_NS);
  localparam logic [17:0] CLK_PERIOD_W = 18'(CLK_PERIOD_NS);

  // ********************************************************
  // Register offsets
  // ********************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_WLO   = 8'h04;
  localparam logic [7:0] OFS_WHI   = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0c;
  localparam logic [7:0] OFS_RBUF  = 8'h10;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int CTRL_WSTART = 0;
  localparam int CTRL_RSTART = 1;
  localparam int CTRL_SEL    = 2;
  localparam int CTRL_POL    = 5;
  localparam int CTRL_ACK    = 6;
  localparam int CTRL_CNT    = 8;
  localparam int CTRL_BUFEN  = 12;
  localparam int CTRL_SER    = 13;
  localparam int CTRL_GAP    = 16;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_OVF    = 1;
  localparam int STAT_LEVEL  = 8;
  localparam int STAT_RBYTE  = 16;
  localparam int RBUF_VALID  = 8;

  // ********************************************************
  // Reset values and sizes
  // ********************************************************
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam int BUF_DEPTH = 7;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_WSTB = 5'h02,
    S_WEND = 5'h04,
    S_GAP  = 5'h08,
    S_RSTB = 5'h10
  } state_t;

endpackage

// ===== rtl/read_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module read_fifo
  import spp_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       RST,
  // Fill side
  input  wire logic       push,
  input  wire logic [7:0] din,
  // Drain side
  input  wire logic       pop,
  output logic      [7:0] dout,
  // Level
  output logic      [2:0] level,
  output logic            full,
  output logic            empty
);

  typedef struct packed {
    logic [BUF_DEPTH-1:0][7:0] mem;
    logic [2:0]                wp;
    logic [2:0]                rp;
    logic [2:0]                cnt;
  } fifo_t;

  fifo_t r_ff;
  fifo_t nxt_r;
  logic  do_push;
  logic  do_pop;

  assign full    = (r_ff.cnt == 3'(BUF_DEPTH));
  assign empty   = (r_ff.cnt == 3'h0);
  assign level   = r_ff.cnt;
  assign dout    = r_ff.mem[r_ff.rp];
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;

  function automatic logic [2:0] wrap_inc(input logic [2:0] p);
    return (p == 3'(BUF_DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  // ********************************************************
  // Storage, oldest entry leaves first
  // ********************************************************
  always_comb begin
    nxt_r = r_ff;
    if (do_push) begin
      nxt_r.mem[r_ff.wp] = din;
      nxt_r.wp = wrap_inc(r_ff.wp);
    end
    if (do_pop) begin
      nxt_r.rp = wrap_inc(r_ff.rp);
    end
    nxt_r.cnt = r_ff.cnt + 3'(do_push) - 3'(do_pop);
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  pop_frees_a: assert property (do_pop && !do_push |=>
    r_ff.cnt == $past(r_ff.cnt) - 3'h1)
    else $error("pop did not free one entry");
  no_overfill_a: assert property (r_ff.cnt <= 3'(BUF_DEPTH))
    else $error("buffer holds more than its depth");

endmodule
`default_nettype wire

// ===== testbench/ext_bus_device.sv
`timescale 1ns/1ps
`default_nettype none
module ext_bus_device (
  // Clock
  input  wire logic        clk,
  // Lines driven by the controller
  input  wire logic [7:0]  p0_out,
  input  wire logic        p0_oe,
  input  wire logic [7:0]  p1_out,
  input  wire logic [7:0]  p1_oe,
  // Pin levels seen by the controller
  output logic      [7:0]  p0_in,
  output logic      [7:0]  p1_in,
  output logic             ack_in,
  // Scenario setup
  input  wire logic [2:0]  sel,
  input  wire logic        pol,
  input  wire logic [7:0]  rdata,
  input  wire logic [15:0] ack_cyc
);
  logic [7:0] p0_drv = 8'hff;
  logic [7:0] p1_drv = 8'hff;
  logic       ack_q  = 1'b1;
  logic       act;
  logic       act_q  = 1'b0;
  int         width  = 0;
  int         wnext;
  int         gap_cnt = 0;
  int         ff_err = 0;
  logic [7:0] bytes_q[$];
  int         width_q[$];
  int         gap_q[$];

  // Undriven pins sit at the pull-up level
  assign act    = p1_oe[sel] && (p1_out[sel] === pol);
  assign wnext  = act_q ? width + 1 : 1;
  assign p0_in  = p0_oe ? p0_out : (act ? rdata : p0_drv);
  assign p1_in  = (p1_oe & p1_out) | (~p1_oe & p1_drv);
  assign ack_in = ack_q;

  always @(posedge clk) begin
    act_q <= act;
    // Hold acknowledge low for the first ack_cyc strobe cycles
    ack_q <= !(act && wnext <= int'(ack_cyc));
    if (act) begin
      width   <= wnext;
      gap_cnt <= 0;
      if (!act_q && p0_oe) begin
        bytes_q.push_back(p0_out);
        if (gap_cnt > 0) begin
          gap_q.push_back(gap_cnt);
        end
      end
    end else begin
      if (act_q) begin
        width_q.push_back(width);
      end
      if (p0_oe) begin
        gap_cnt <= gap_cnt + 1;
        if (gap_cnt >= 1 && p0_out !== 8'hff) begin
          ff_err <= ff_err + 1;
        end
      end else begin
        gap_cnt <= 0;
      end
    end
  end

  // One strobed byte into the read buffer; strobe idles at the pull-up level
  task automatic pulse(input logic [7:0] d);
    @(posedge clk);
    p0_drv <= d;
    repeat (3) @(posedge clk);
    p1_drv[sel] <= pol;
    repeat (4) @(posedge clk);
    p1_drv[sel] <= !pol;
    repeat (6) @(posedge clk);
    p1_drv[sel] <= 1'b1;
    p0_drv <= 8'hff;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import spp_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, p0_oe;
  logic        ack_in, pol;
  logic [7:0]  paddr, p0_in, p0_out, p1_in, p1_out, p1_oe, rdata;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] ack_cyc;
  logic [2:0]  sel;
  logic        err_q;
  int          err_count, n_compared, gmin;

  strobed_parallel_port DUT (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .P0_IN(p0_in),
    .P0_OUT(p0_out), .P0_OE(p0_oe), .P1_IN(p1_in), .P1_OUT(p1_out),
    .P1_OE(p1_oe), .ACK_IN(ack_in));
  ext_bus_device partner (.clk(clk), .p0_out(p0_out), .p0_oe(p0_oe),
    .p1_out(p1_out), .p1_oe(p1_oe), .p0_in(p0_in), .p1_in(p1_in),
    .ack_in(ack_in), .sel(sel), .pol(pol), .rdata(rdata),
    .ack_cyc(ack_cyc));

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  // ********************************************************
  // Bus and check tasks
  // ********************************************************
  task automatic finish_test();
    $display("%0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      err_count++;
      $display("BAD %0t bus stall at %h", $time, a);
      finish_test();
    end
    rd_q  = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls busy; a fixed wait would hide a late or stuck sequencer
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      apb(1'b0, OFS_STAT, 32'h0);
      k++;
    end while (rd_q[STAT_BUSY] !== 1'b0 && k < 3000);
    if (k >= 3000) begin
      err_count++;
      $display("BAD %0t busy never cleared", $time);
      finish_test();
    end
  endtask

  function automatic logic [31:0] ctrl_w(input logic [2:0] s,
    input logic p, input logic a, input logic [2:0] c,
    input logic [7:0] g, input logic [1:0] st, input logic [1:0] bs);
    ctrl_w = 32'(st) | (32'(s) << CTRL_SEL) | (32'(p) << CTRL_POL)
           | (32'(a) << CTRL_ACK) | (32'(c) << CTRL_CNT)
           | (32'(bs) << CTRL_BUFEN) | (32'(g) << CTRL_GAP);
  endfunction

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; sel = 3'h0; pol = 1'b1;
    rdata = 8'h00; ack_cyc = 16'h0; err_count = 0; n_compared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd_q, 32'h1 << CTRL_POL);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    chk({15'h0, p0_oe, p1_oe, p0_out}, 32'h00ff);
    // Single byte; a data write while busy must be ignored
    sel <= 3'h3;
    apb(1'b1, OFS_WLO, 32'ha5);
    apb(1'b1, OFS_CTRL, ctrl_w(3'h3, 1'b1, 1'b0, 3'h0, 8'h0, 2'h1, 2'h0));
    apb(1'b1, OFS_WLO, 32'h11);
    wait_idle();
    apb(1'b0, OFS_WLO, 32'h0);
    chk(rd_q, 32'ha5);
    chk(32'(partner.bytes_q[0]), 32'ha5);
    chk(32'(partner.width_q[0]), 32'd75);
    chk({15'h0, p0_oe, p1_oe, p0_out}, 32'h00ff);
    // Eight bytes, low strobe, gap count 2
    sel <= 3'h6;
    pol <= 1'b0;
    apb(1'b1, OFS_WLO, 32'h13121110);
    apb(1'b1, OFS_WHI, 32'h17161514);
    apb(1'b1, OFS_CTRL, ctrl_w(3'h6, 1'b0, 1'b0, 3'h7, 8'h2, 2'h1, 2'h0));
    wait_idle();
    gmin = (GAP_BASE_NS + 2 * GAP_STEP_NS + CLK_PERIOD_NS - 1)
           / CLK_PERIOD_NS;
    for (int i = 0; i < 8; i++) begin
      chk(32'(partner.bytes_q[1 + i]), 32'h10 + 32'(i));
      chk(32'(partner.width_q[1 + i]), 32'd75);
    end
    for (int i = 0; i < 7; i++) begin
      chk(32'(partner.gap_q[i] >= gmin && partner.gap_q[i] <= gmin + 5),
          32'h1);
    end
    chk(32'(partner.ff_err), 32'h0);
    // Acknowledge stretches the strobe
    sel <= 3'h0;
    pol <= 1'b1;
    ack_cyc <= 16'd150;
    apb(1'b1, OFS_WLO, 32'h5c);
    apb(1'b1, OFS_CTRL, ctrl_w(3'h0, 1'b1, 1'b1, 3'h0, 8'h0, 2'h1, 2'h0));
    wait_idle();
    ack_cyc <= 16'h0;
    chk(32'(partner.bytes_q[9]), 32'h5c);
    chk(32'(partner.width_q[9] >= 150 && partner.width_q[9] <= 156),
        32'h1);
    // Strobed reads in both polarities
    sel <= 3'h5;
    for (int j = 0; j < 2; j++) begin
      pol   <= j[0];
      rdata <= 8'h5a ^ {8{j[0]}};
      apb(1'b1, OFS_CTRL, ctrl_w(3'h5, j[0], 1'b0, 3'h0, 8'h0, 2'h2, 2'h0));
      wait_idle();
      chk({24'h0, rd_q[STAT_RBYTE +: 8]}, 32'(rdata));
      chk(32'(partner.width_q[10 + j]), 32'd75);
    end
    // Buffer: overfill, drain in order, clear overflow
    sel <= 3'h2;
    pol <= 1'b0;
    apb(1'b1, OFS_CTRL, ctrl_w(3'h2, 1'b0, 1'b0, 3'h0, 8'h0, 2'h0, 2'h1));
    for (int i = 0; i < 9; i++) begin
      partner.pulse(8'h30 + 8'(i));
    end
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd_q[STAT_LEVEL +: 3]), 32'd7);
    chk(32'(rd_q[STAT_OVF]), 32'h1);
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, OFS_RBUF, 32'h0);
      chk(32'(rd_q[8:0]), 32'h130 + 32'(i));
    end
    apb(1'b0, OFS_RBUF, 32'h0);
    chk(32'(rd_q[RBUF_VALID]), 32'h0);
    apb(1'b1, OFS_STAT, 32'h1 << STAT_OVF);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd_q[STAT_OVF]), 32'h0);
    // Serial function active blocks the buffer
    apb(1'b1, OFS_CTRL, ctrl_w(3'h2, 1'b0, 1'b0, 3'h0, 8'h0, 2'h0, 2'h3));
    partner.pulse(8'h77);
    apb(1'b0, OFS_STAT, 32'h0);
    chk(32'(rd_q[STAT_LEVEL +: 3]), 32'd0);
    apb(1'b1, OFS_CTRL, ctrl_w(3'h2, 1'b0, 1'b0, 3'h0, 8'h0, 2'h0, 2'h1));
    partner.pulse(8'h78);
    apb(1'b0, OFS_RBUF, 32'h0);
    chk(32'(rd_q[8:0]), 32'h178);
    finish_test();
  end
endmodule
`default_nettype wire
